// ===== rtl/pmc_power_mode_controller.v
// Power-mode controller: APB register file plus mode sequencer driving clock
// gates, oscillator stops, regulator bias and power-off outputs.
// Assumes the power-off outputs are honoured by an always-on domain that
// re-asserts presetn when it restores power after a qualifying reset.
//
// Behaviour
// - Normal mode clocks core and enabled peripherals
// - Idle bit halts core, peripherals run
// - Permitted wake event resumes code execution
// - Suspend needs fast clock 0, normal bias
// - Suspend/snooze halt clocks, stop fast oscillators
// - Snooze needs fast clock 0, low bias
// - Timers 3, 4 may run from low oscillator
// - Only listed events wake suspend or snooze
// - Stop entered with select clear; any reset exits
// - Shutdown with select set; pin/POR exit
// - Stop/shutdown power off nets, pins hold
// - Unused peripheral clocks are gated off
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.vh"
module pmc_power_mode_controller #(
    parameter NPERIPH = 8
) (
    // APB
    input  wire               pclk,
    input  wire               presetn,
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [11:0]        paddr,
    input  wire [31:0]        pwdata,
    output reg  [31:0]        prdata,
    output wire               pready,
    output wire               pslverr,
    // Wake sources (asynchronous)
    input  wire               any_irq,
    input  wire               timer4_event,
    input  wire               serial_peripheral_port_activity,
    input  wire               two_wire_port_slave_activity,
    input  wire               port_match_event,
    input  wire               comparator0_out,
    input  wire               configurable_logic_unit_irq,
    // Reset cause of the most recent reset (asynchronous levels)
    input  wire               external_reset_pin_n,
    input  wire               power_on_reset,
    // Clock and power controls
    output reg                core_clk_en,
    output reg  [NPERIPH-1:0] periph_clk_en,
    output reg                timer34_lowfreq_en,
    output reg                fast_oscillator_0_en,
    output reg                fast_oscillator_1_en,
    output reg                regulator_low_bias,
    output reg                power_off,
    output reg                pin_retain,
    output reg  [2:0]         power_mode
);
    localparam ST_NORMAL  = 3'h0;
    localparam ST_IDLE    = 3'h1;
    localparam ST_SUSPEND = 3'h2;
    localparam ST_SNOOZE  = 3'h3;
    localparam ST_STOP    = 3'h4;
    localparam ST_SHUT    = 3'h5;

    reg [2:0]         state_reg;
    reg [2:0]         state_next;
    reg [1:0]         pc0_reg;
    reg [1:0]         pc1_reg;
    reg               shutdown_select_reg;
    reg [1:0]         clock_select_reg;
    reg [NPERIPH-1:0] periph_enable_reg;
    reg [5:0]         wake_enable_reg;
    reg               timer34_lowfreq_reg;
    reg               cmp0_prev_reg;
    reg [1:0]         reset_cause_reg;
    reg               cause_taken_reg;
    reg [1:0]         cause_wait_reg;

    wire [7:0] wake_sync;
    wire       wr_en;
    wire       rd_en;
    wire       irq_s;
    wire       cmp0_s;
    wire       cmp0_fall;
    wire [5:0] deep_wake_src;
    wire       deep_wake;

    // Bits 7:6 carry the reset cause, bits 5:0 the wake sources in wake-enable order
    pmc_sync #(
        .WIDTH (8)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({~external_reset_pin_n, power_on_reset,
                    configurable_logic_unit_irq, comparator0_out,
                    port_match_event, two_wire_port_slave_activity,
                    serial_peripheral_port_activity, timer4_event}),
        .sync_out (wake_sync)
    );

    // Any interrupt wakes idle only; deep sleep ignores it
    pmc_sync #(
        .WIDTH (1)
    ) u_irq_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (any_irq),
        .sync_out (irq_s)
    );

    function is_reg;
        input [11:0] addr;
        input [11:0] off;
        begin
            is_reg = (addr[11:2] == off[11:2]);
        end
    endfunction

    // Mode groups decoded in several places; one definition keeps the clock,
    // oscillator and power outputs in step with each other
    function runs_fast;
        input [2:0] st;
        begin
            runs_fast = (st == ST_NORMAL) || (st == ST_IDLE);
        end
    endfunction

    function is_deep;
        input [2:0] st;
        begin
            is_deep = (st == ST_SUSPEND) || (st == ST_SNOOZE);
        end
    endfunction

    function is_off;
        input [2:0] st;
        begin
            is_off = (st == ST_STOP) || (st == ST_SHUT);
        end
    endfunction

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~pwrite;
    // Every register answers in its access cycle, so no wait states
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign cmp0_s  = wake_sync[4];
    assign cmp0_fall = cmp0_prev_reg & ~cmp0_s;
    assign deep_wake_src = {wake_sync[5], cmp0_fall, wake_sync[3], wake_sync[2], wake_sync[1], wake_sync[0]};
    assign deep_wake     = |(deep_wake_src & wake_enable_reg);

    // Reset cause is caught after release, never under the async reset.
    // The synchroniser clears with presetn, so its output means nothing until
    // the third edge after release; sampling earlier would always read zeros.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_cause_reg <= 2'h0;
            cause_wait_reg  <= 2'h0;
            cause_taken_reg <= 1'b0;
            cmp0_prev_reg   <= 1'b0;
        end else begin
            cmp0_prev_reg <= cmp0_s;
            if (!cause_taken_reg) begin
                if (cause_wait_reg == `PMC_CAUSE_WAIT) begin
                    cause_taken_reg <= 1'b1;
                    reset_cause_reg <= wake_sync[7:6];
                end else begin
                    cause_wait_reg <= cause_wait_reg + 2'h1;
                end
            end
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_NORMAL: begin
                if (pc0_reg[`PMC_PC0_POWEROFF_BIT])
                    state_next = shutdown_select_reg ? ST_SHUT : ST_STOP;
                else if (pc0_reg[`PMC_PC0_IDLE_BIT])
                    state_next = ST_IDLE;
                else if (pc1_reg[`PMC_PC1_DEEP_BIT] && clock_select_reg == `PMC_CLK_FAST0)
                    state_next = ST_SUSPEND;
                else if (pc1_reg[`PMC_PC1_LOWBIAS_BIT] && clock_select_reg == `PMC_CLK_FAST0)
                    state_next = ST_SNOOZE;
            end
            ST_IDLE: begin
                if (irq_s)
                    state_next = ST_NORMAL;
            end
            ST_SUSPEND, ST_SNOOZE: begin
                if (deep_wake)
                    state_next = ST_NORMAL;
            end
            // only pin or POR reset leaves shutdown
            ST_STOP, ST_SHUT: state_next = state_reg;
            default: state_next = ST_NORMAL;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg           <= ST_NORMAL;
            pc0_reg             <= 2'h0;
            pc1_reg             <= 2'h0;
            shutdown_select_reg <= 1'b0;
            clock_select_reg    <= `PMC_CLOCK_SELECT_RST;
            periph_enable_reg   <= {NPERIPH{1'b1}};
            wake_enable_reg     <= `PMC_WAKE_ENABLE_RST;
            timer34_lowfreq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // Core is halted outside normal mode; a write there is a stray, so drop it
            if (wr_en && state_reg == ST_NORMAL) begin
                if (is_reg(paddr, `PMC_POWER_CONTROL_0_OFF))
                    pc0_reg <= pwdata[1:0];
                if (is_reg(paddr, `PMC_POWER_CONTROL_1_OFF))
                    pc1_reg <= pwdata[1:0];
                if (is_reg(paddr, `PMC_REGULATOR_CTRL_OFF))
                    shutdown_select_reg <= pwdata[`PMC_REG_SHUTDOWN_SEL_BIT];
                if (is_reg(paddr, `PMC_CLOCK_SELECT_OFF))
                    clock_select_reg <= pwdata[1:0];
                if (is_reg(paddr, `PMC_PERIPH_ENABLE_OFF))
                    periph_enable_reg <= pwdata[NPERIPH-1:0];
                if (is_reg(paddr, `PMC_WAKE_ENABLE_OFF)) begin
                    wake_enable_reg     <= pwdata[5:0];
                    timer34_lowfreq_reg <= pwdata[8];
                end
            end
            // Writes are dropped outside normal mode, so this clear never meets one
            // clear request on wake
            if (state_next == ST_NORMAL && state_reg != ST_NORMAL) begin
                pc0_reg <= 2'h0;
                pc1_reg <= 2'h0;
            end
        end
    end

    // Outputs are registered so gates never glitch during mode changes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_clk_en          <= 1'b1;
            periph_clk_en        <= {NPERIPH{1'b1}};
            timer34_lowfreq_en   <= 1'b0;
            fast_oscillator_0_en <= 1'b1;
            fast_oscillator_1_en <= 1'b1;
            regulator_low_bias   <= 1'b0;
            power_off            <= 1'b0;
            pin_retain           <= 1'b0;
            power_mode           <= `PMC_MODE_NORMAL;
        end else begin
            power_mode <= state_next;
            core_clk_en <= (state_next == ST_NORMAL);
            periph_clk_en <= runs_fast(state_next) ? periph_enable_reg : {NPERIPH{1'b0}};
            fast_oscillator_0_en <= runs_fast(state_next);
            fast_oscillator_1_en <= runs_fast(state_next);
            // timers 3 and 4 on low oscillator
            timer34_lowfreq_en <= timer34_lowfreq_reg && is_deep(state_next);
            regulator_low_bias <= (state_next == ST_SNOOZE);
            power_off  <= is_off(state_next);
            pin_retain <= is_off(state_next);
        end
    end

    always @* begin
        prdata = 32'h0;
        if (rd_en) begin
            if (is_reg(paddr, `PMC_POWER_CONTROL_0_OFF))
                prdata = {30'h0, pc0_reg};
            else if (is_reg(paddr, `PMC_POWER_CONTROL_1_OFF))
                prdata = {30'h0, pc1_reg};
            else if (is_reg(paddr, `PMC_REGULATOR_CTRL_OFF))
                prdata = {31'h0, shutdown_select_reg};
            else if (is_reg(paddr, `PMC_CLOCK_SELECT_OFF))
                prdata = {30'h0, clock_select_reg};
            else if (is_reg(paddr, `PMC_PERIPH_ENABLE_OFF))
                prdata = {{(32-NPERIPH){1'b0}}, periph_enable_reg};
            else if (is_reg(paddr, `PMC_WAKE_ENABLE_OFF))
                prdata = {23'h0, timer34_lowfreq_reg, 2'h0, wake_enable_reg};
            // Status is read-only; a write to it matches no register
            else if (is_reg(paddr, `PMC_STATUS_OFF))
                prdata = {27'h0, reset_cause_reg, state_reg};
        end
    end
endmodule
`default_nettype wire

// ===== rtl/pmc_defs.vh
// Constants for the power-mode controller: register offsets, bit positions,
// reset values and mode codes. Included by the controller, checker and testbench by bare name.
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

// Register byte offsets on APB
`define PMC_POWER_CONTROL_0_OFF  12'h000
`define PMC_POWER_CONTROL_1_OFF  12'h004
`define PMC_REGULATOR_CTRL_OFF   12'h008
`define PMC_CLOCK_SELECT_OFF     12'h00c
`define PMC_PERIPH_ENABLE_OFF    12'h010
`define PMC_WAKE_ENABLE_OFF      12'h014
`define PMC_STATUS_OFF           12'h018

// power_control_0 bits
`define PMC_PC0_IDLE_BIT         0
`define PMC_PC0_POWEROFF_BIT     1
// power_control_1 bits
`define PMC_PC1_DEEP_BIT         0
`define PMC_PC1_LOWBIAS_BIT      1
// regulator_control bits
`define PMC_REG_SHUTDOWN_SEL_BIT 0
// Core clock source codes
`define PMC_CLK_FAST0            2'h0
`define PMC_CLK_FAST1            2'h1
`define PMC_CLK_LOWFREQ          2'h2

// Reset values
`define PMC_PERIPH_ENABLE_RST    8'hff
`define PMC_WAKE_ENABLE_RST      6'h3f
`define PMC_CLOCK_SELECT_RST     2'h0
// Edges after reset release before the reset cause is sampled
`define PMC_CAUSE_WAIT           2'h2

// Mode codes
`define PMC_MODE_NORMAL          3'h0
`define PMC_MODE_IDLE            3'h1
`define PMC_MODE_SUSPEND         3'h2
`define PMC_MODE_SNOOZE          3'h3
`define PMC_MODE_STOP            3'h4
`define PMC_MODE_SHUTDOWN        3'h5

`endif

// ===== rtl/pmc_sync.v
// Two-flop synchroniser bank for asynchronous wake and reset-cause inputs.
// Assumes pclk domain; inputs may change at any time.
`timescale 1ns/1ps
`default_nettype none
module pmc_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ===== bench/pmc_chk.sv
// Checker for the power-mode controller: ties mode to clock, bias and power outputs.
// Assumes binding to the controller top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.vh"
module pmc_chk #(parameter NPERIPH = 8) (
    // Clock, reset and bus
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    // Wake sources
    input wire logic               any_irq,
    input wire logic               timer4_event,
    input wire logic               serial_peripheral_port_activity,
    input wire logic               two_wire_port_slave_activity,
    input wire logic               port_match_event,
    input wire logic               comparator0_out,
    input wire logic               configurable_logic_unit_irq,
    // Controls
    input wire logic               core_clk_en,
    input wire logic [NPERIPH-1:0] periph_clk_en,
    input wire logic               timer34_lowfreq_en,
    input wire logic               fast_oscillator_0_en,
    input wire logic               fast_oscillator_1_en,
    input wire logic               regulator_low_bias,
    input wire logic               power_off,
    input wire logic               pin_retain,
    input wire logic [2:0]         power_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire slp = power_mode == `PMC_MODE_SUSPEND || power_mode == `PMC_MODE_SNOOZE;
    wire off = power_mode == `PMC_MODE_STOP || power_mode == `PMC_MODE_SHUTDOWN;
    wire ev  = timer4_event | serial_peripheral_port_activity | two_wire_port_slave_activity
             | port_match_event | configurable_logic_unit_irq;
    sequence s_idle_wr;
        psel && penable && pwrite && paddr == `PMC_POWER_CONTROL_0_OFF && pwdata[1:0] == 2'h1
        && power_mode == `PMC_MODE_NORMAL && !any_irq;
    endsequence
    sequence s_irq;
        power_mode == `PMC_MODE_IDLE && any_irq ##1 any_irq [*2];
    endsequence
    // Comparator stable means no falling edge can be on its way in
    sequence s_quiet;
        slp && !ev && $stable(comparator0_out);
    endsequence
    a_normal_clocks: assert property (
        power_mode == `PMC_MODE_NORMAL |-> core_clk_en && fast_oscillator_0_en && fast_oscillator_1_en)
        else $error("normal mode lost a clock");
    a_idle_entry: assert property (s_idle_wr |-> ##2 power_mode == `PMC_MODE_IDLE)
        else $error("idle not entered");
    a_idle_core: assert property (
        power_mode == `PMC_MODE_IDLE |-> !core_clk_en && fast_oscillator_0_en)
        else $error("idle clocks wrong");
    a_idle_wake: assert property (s_irq |=> power_mode == `PMC_MODE_NORMAL)
        else $error("interrupt did not wake idle");
    a_sleep_clocks: assert property (
        slp |-> !core_clk_en && periph_clk_en == '0 && !fast_oscillator_0_en && !fast_oscillator_1_en)
        else $error("sleep clocks running");
    a_bias_snooze: assert property (regulator_low_bias == (power_mode == `PMC_MODE_SNOOZE))
        else $error("regulator bias wrong");
    a_timer_gate: assert property (timer34_lowfreq_en |-> slp)
        else $error("low-frequency timers outside sleep");
    a_sleep_hold: assert property (s_quiet [*4] |=> power_mode == $past(power_mode))
        else $error("woke with no wake source");
    a_off_hold: assert property (off |=> $stable(power_mode))
        else $error("left power-off without reset");
    a_off_power: assert property (power_off |-> pin_retain && off && !core_clk_en)
        else $error("power-off outputs wrong");
endmodule
bind pmc_power_mode_controller pmc_chk #(.NPERIPH(NPERIPH)) u_chk (.*);
`default_nettype wire

// ===== bench/test_power_mode_controller.sv
// Testbench for the power-mode controller: APB calls with expected values.
// Assumes the mode codes of pmc_defs.vh; APB calls wait on pready.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_power_mode_controller;
    localparam logic [11:0] PC0 = `PMC_POWER_CONTROL_0_OFF, PC1 = `PMC_POWER_CONTROL_1_OFF,
        RGC = `PMC_REGULATOR_CTRL_OFF, CKS = `PMC_CLOCK_SELECT_OFF, PEN = `PMC_PERIPH_ENABLE_OFF,
        WKE = `PMC_WAKE_ENABLE_OFF, STS = `PMC_STATUS_OFF;
    localparam logic [2:0] NRM = `PMC_MODE_NORMAL, IDL = `PMC_MODE_IDLE, SUS = `PMC_MODE_SUSPEND,
        SNZ = `PMC_MODE_SNOOZE, STP = `PMC_MODE_STOP, SHD = `PMC_MODE_SHUTDOWN;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        any_irq = 0, external_reset_pin_n = 1, power_on_reset = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic [5:0]  ws = 0;
    logic        pready, pslverr, core_clk_en, timer34_lowfreq_en, fast_oscillator_0_en;
    logic        fast_oscillator_1_en, regulator_low_bias, power_off, pin_retain;
    logic [7:0]  periph_clk_en;
    logic [2:0]  power_mode, sm;
    int          n_fail = 0, comparisons = 0, cyc = 0, i;
    wire timer4_event = ws[0];
    wire serial_peripheral_port_activity = ws[1];
    wire two_wire_port_slave_activity = ws[2];
    wire port_match_event = ws[3];
    // Comparator idles high so that raising ws[4] gives a falling edge
    wire comparator0_out = ~ws[4];
    wire configurable_logic_unit_irq = ws[5];
    pmc_power_mode_controller #(.NPERIPH(8)) dut (.*);
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    task finish_test;
        $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        `CHK(rdat, e)
        `CHK(pslverr, 1'b0)
    endtask
    task mode(input logic [2:0] m);
        repeat (10) if (power_mode !== m) @(posedge pclk);
        `CHK(power_mode, m)
    endtask
    task rst(input logic pin_n);
        presetn <= 0;
        external_reset_pin_n <= pin_n;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        external_reset_pin_n <= 1;
    endtask
    initial begin
        rst(1);
        rd(PEN, 32'hff);
        rd(WKE, 32'h3f);
        rd(CKS, 32'h0);
        rd(STS, 32'h0);
        rd(12'h01c, 32'h0);
        `CHK({core_clk_en, fast_oscillator_0_en, fast_oscillator_1_en, periph_clk_en}, 11'h7ff)
        wr(PEN, 32'h0f);
        // Enable register lands at the write edge, the gate one edge later
        repeat (2) @(posedge pclk);
        `CHK(periph_clk_en, 8'h0f)
        wr(PC0, 32'h1);
        mode(IDL);
        `CHK({core_clk_en, periph_clk_en}, 9'h00f)
        // Writes outside normal mode must be dropped
        wr(PEN, 32'hff);
        any_irq <= 1;
        mode(NRM);
        any_irq <= 0;
        rd(PC0, 32'h0);
        rd(PEN, 32'h0f);
        // Sleep request is refused while the core runs from another clock
        wr(CKS, 32'h1);
        wr(PC1, 32'h1);
        repeat (4) @(posedge pclk);
        `CHK(power_mode, NRM)
        wr(PC1, 32'h0);
        wr(CKS, 32'h0);
        for (i = 0; i < 6; i++) begin
            sm = i[0] ? SNZ : SUS;
            wr(PC1, i[0] ? 32'h2 : 32'h1);
            mode(sm);
            `CHK({regulator_low_bias, core_clk_en, periph_clk_en, fast_oscillator_0_en, fast_oscillator_1_en},
                {i[0], 11'h0})
            any_irq <= 1;
            repeat (6) @(posedge pclk);
            `CHK(power_mode, sm)
            any_irq <= 0;
            ws[i] <= 1;
            mode(NRM);
            rd(PC1, 32'h0);
            ws <= 0;
            repeat (4) @(posedge pclk);
        end
        wr(WKE, 32'h13e);
        wr(PC1, 32'h2);
        mode(SNZ);
        `CHK(timer34_lowfreq_en, 1'b1)
        ws[0] <= 1;
        repeat (6) @(posedge pclk);
        `CHK(power_mode, SNZ)
        ws[1] <= 1;
        mode(NRM);
        `CHK(timer34_lowfreq_en, 1'b0)
        ws <= 0;
        wr(RGC, 32'h0);
        wr(PC0, 32'h2);
        mode(STP);
        `CHK({power_off, pin_retain, core_clk_en}, 3'h6)
        rst(1);
        mode(NRM);
        wr(RGC, 32'h1);
        wr(PC0, 32'h2);
        mode(SHD);
        `CHK({power_off, pin_retain, core_clk_en}, 3'h6)
        rst(0);
        mode(NRM);
        rd(STS, 32'h10);
        finish_test();
    end
endmodule
`default_nettype wire
